/* File: dalsa_defs.vh */
// constants for the divide, adjust, logic and shift datapath
// assumes one include per compile unit; guarded against repeats
`ifndef DALSA_DEFS_VH
`define DALSA_DEFS_VH

// ============================================================
// operation codes
`define DALSA_OP_NOT   5'h00
`define DALSA_OP_AND   5'h01
`define DALSA_OP_OR    5'h02
`define DALSA_OP_XOR   5'h03
`define DALSA_OP_TEST  5'h04
`define DALSA_OP_SHL   5'h05
`define DALSA_OP_SHR   5'h06
`define DALSA_OP_SAR   5'h07
`define DALSA_OP_ROL   5'h08
`define DALSA_OP_ROR   5'h09
`define DALSA_OP_RCL   5'h0A
`define DALSA_OP_RCR   5'h0B
`define DALSA_OP_DIV   5'h0C
`define DALSA_OP_SIGNED_DIVIDE  5'h0D
`define DALSA_OP_AAM   5'h0E
`define DALSA_OP_AAD   5'h0F
`define DALSA_OP_CBW   5'h10
`define DALSA_OP_CWD   5'h11

// ============================================================
// flag bit positions in the status word
`define DALSA_CF 0
`define DALSA_PF 2
`define DALSA_AF 4
`define DALSA_ZF 6
`define DALSA_SF 7
`define DALSA_OF 11

// ============================================================
// reset values and limits
`define DALSA_FLAGS_RST 16'h0000
`define DALSA_DATA_RST  16'h0000
`define DALSA_BYTE_MASK 16'h00FF
`define DALSA_WORD_MASK 16'hFFFF
`define DALSA_TEN       8'h0A
`define DALSA_UBYTE_MAX 32'h000000FF
`define DALSA_UWORD_MAX 32'h0000FFFF
`define DALSA_SBYTE_MAX 32'h0000007F
`define DALSA_SWORD_MAX 32'h00007FFF
`define DALSA_ONE_SHIFT 8'h01

`endif

/* File: dalsa_alu.v */
// divide, decimal adjust, sign extend, logic and shift datapath
// assumes operands stay steady only in the start cycle; all results
// are latched, so the core may change its inputs afterwards
`timescale 1ns/1ps
`include "dalsa_defs.vh"

// Functional notes
// RULE1: decimal adjust after multiply splits the low byte into two digits.
// RULE2: that adjust sets parity, sign, zero; other flags left alone.
// RULE3: byte divide: high:low by source, quotient low, remainder high.
// RULE4: word divide: extension:accumulator by source, quotient/remainder.
// RULE5: unsigned quotient overflow or zero divisor raises divide error.
// RULE6: unsigned divide truncates; arithmetic flags left undefined.
// RULE7: signed byte quotient must lie within +127 to -127.
// RULE8: signed word quotient must lie within +32767 to -32767.
// RULE9: signed quotient out of range or zero divisor raises error.
// RULE10: signed divide truncates toward zero, remainder takes dividend sign.
// RULE11: adjust before divide sets parity, sign, zero from result.
// RULE12: byte to word copies bit 7 over the high byte, no flags.
// RULE13: word to double copies bit 15 over the extension, no flags.
// RULE14: logical ops clear overflow and carry, set sign, zero, parity.
// RULE15: sign is top bit, zero for all-zero, parity for even ones.
// RULE16: not writes the complement and leaves every flag alone.
// RULE17: and, or, xor write the bitwise result to the destination.
// RULE18: test updates flags from the and but writes nothing back.
// RULE19: shift count is one or the count register low byte, to 255.
// RULE20: shifts put last bit out in carry, result flags follow.
// RULE21: single shift overflow is top bit changed; multi leaves it.
// RULE22: left shifts, logical or arithmetic, fill zeros from below.
// RULE23: logical right shift fills zeros from the top.
// RULE24: arithmetic right shift fills with the original top bit.
// RULE25: rotates through carry treat carry as an extra operand bit.
// RULE26: plain rotate right mirrors plain rotate left.
// RULE27: the adjust puts low byte / 10 high and remainder low.
// RULE28: adjust before divide makes low = high*10 + low, clears high.
module dalsa_alu (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_sys_rst,
  // request
  input  wire        i_start,
  input  wire [4:0]  i_op,
  input  wire        i_word,
  input  wire        i_count_sel,
  // operands
  input  wire [15:0] i_dst,
  input  wire [15:0] i_src,
  input  wire [15:0] i_acc,
  input  wire [15:0] i_ext,
  input  wire [7:0]  i_count_low,
  input  wire [15:0] i_flags,
  // handshake
  output wire        o_busy,
  output reg         o_done,
  output reg         o_divide_error,
  // results
  output reg  [15:0] o_result,
  output reg         o_write_dst,
  output reg  [15:0] o_acc,
  output reg         o_write_acc,
  output reg  [15:0] o_ext,
  output reg         o_write_ext,
  output reg  [15:0] o_flags,
  output reg         o_write_flags
);

  localparam ST_IDLE  = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // ==========================================================
  // helper functions
  function [15:0] wmask;
    input w;
    begin
      wmask = w ? `DALSA_WORD_MASK : `DALSA_BYTE_MASK;
    end
  endfunction

  function topbit;
    input w;
    input [15:0] v;
    begin
      topbit = w ? v[15] : v[7];
    end
  endfunction

  function [15:0] at_top;
    input w;
    input b;
    begin
      at_top = w ? {b, 15'h0000} : {8'h00, b, 7'h00};
    end
  endfunction

  // sign, zero and parity into a flag word
  function [15:0] szp;
    input w;
    input [15:0] v;
    input [15:0] f;
    reg   [15:0] m;
    begin
      m = v & wmask(w);
      szp = f;
      szp[`DALSA_SF] = topbit(w, m);               // RULE15
      szp[`DALSA_ZF] = (m == 16'h0000);            // RULE15
      szp[`DALSA_PF] = ~(^m);                      // RULE15
    end
  endfunction

  // one bit position of any shift or rotate: {carry, value}
  function [16:0] step;
    input [4:0]  op;
    input        w;
    input [15:0] v;
    input        c;
    reg          t;
    begin
      t = topbit(w, v);
      case (op)
        `DALSA_OP_SHL: step = {t, (v << 1) & wmask(w)};    // RULE22
        `DALSA_OP_SHR: step = {v[0], v >> 1};              // RULE23
        `DALSA_OP_SAR: step = {v[0], (v >> 1) | at_top(w, t)}; // RULE24
        `DALSA_OP_ROL: step = {t, ((v << 1) | {15'h0000, t}) & wmask(w)};
        `DALSA_OP_ROR: step = {v[0], (v >> 1) | at_top(w, v[0])}; // RULE26
        `DALSA_OP_RCL: step = {t, ((v << 1) | {15'h0000, c}) & wmask(w)};
        `DALSA_OP_RCR: step = {v[0], (v >> 1) | at_top(w, c)}; // RULE25
        default:       step = {c, v};
      endcase
    end
  endfunction

  // ==========================================================
  // division, unsigned and signed, done in one cycle
  reg        sgn;
  reg        neg_d;
  reg        neg_s;
  reg [31:0] dvd;
  reg [15:0] dvs;
  reg [31:0] dvd_mag;
  reg [15:0] dvs_mag;
  reg [31:0] q_mag;
  reg [15:0] r_mag;
  reg [31:0] r_full;
  reg [31:0] limit;
  reg [31:0] quo;
  reg [15:0] rem;
  reg        div_err;

  always @* begin
    sgn = (i_op == `DALSA_OP_SIGNED_DIVIDE);
    if (i_word) begin
      dvd = {i_ext, i_acc};                                  // RULE4
      dvs = i_src;
    end else begin
      dvd = {{16{sgn & i_acc[15]}}, i_acc};                  // RULE3
      dvs = {{8{sgn & i_src[7]}}, i_src[7:0]};
    end
    neg_d = sgn & dvd[31];
    neg_s = sgn & dvs[15];
    dvd_mag = neg_d ? (32'h00000000 - dvd) : dvd;
    dvs_mag = neg_s ? (16'h0000 - dvs) : dvs;
    // magnitudes divide truncating, which is truncation toward zero
    if (dvs_mag == 16'h0000) begin
      q_mag  = 32'h00000000;
      r_full = 32'h00000000;
      r_mag  = 16'h0000;
    end else begin
      q_mag  = dvd_mag / {16'h0000, dvs_mag};                // RULE6
      // remainder is below the divisor, so the top half is always zero
      r_full = dvd_mag % {16'h0000, dvs_mag};
      r_mag  = r_full[15:0];
    end
    if (sgn)
      limit = i_word ? `DALSA_SWORD_MAX : `DALSA_SBYTE_MAX;   // RULE7 RULE8
    else
      limit = i_word ? `DALSA_UWORD_MAX : `DALSA_UBYTE_MAX;
    // zero divisor and oversize quotient both trap
    div_err = (dvs_mag == 16'h0000) || (q_mag > limit);     // RULE5 RULE9
    quo = (neg_d ^ neg_s) ? (32'h00000000 - q_mag) : q_mag;  // RULE10
    rem = neg_d ? (16'h0000 - r_mag) : r_mag;                // RULE10
  end

  // ==========================================================
  // decimal adjust terms
  wire [7:0]  aam_hi = i_acc[7:0] / `DALSA_TEN;              // RULE27
  wire [7:0]  aam_lo = i_acc[7:0] % `DALSA_TEN;              // RULE27
  wire [15:0] aad_wide = i_acc[15:8] * `DALSA_TEN;
  wire [7:0]  aad_lo = aad_wide[7:0] + i_acc[7:0];           // RULE28

  // ==========================================================
  // logical results
  reg [15:0] logic_res;

  always @* begin
    case (i_op)
      `DALSA_OP_NOT: logic_res = ~i_dst;                     // RULE16
      `DALSA_OP_OR:  logic_res = i_dst | i_src;              // RULE17
      `DALSA_OP_XOR: logic_res = i_dst ^ i_src;              // RULE17
      default:       logic_res = i_dst & i_src;              // RULE17 RULE18
    endcase
  end

  // shift count chosen from the instruction form
  wire [7:0] count_eff = i_count_sel ? i_count_low :
                                       `DALSA_ONE_SHIFT;   // RULE19

  // ==========================================================
  // sequencing state for shifts and rotates of one or more positions
  reg        state;
  reg [4:0]  op_q;
  reg        word_q;
  reg [7:0]  count;
  reg        single;
  reg [15:0] val;
  reg        cf;
  reg        orig_top;
  reg [15:0] flags_q;

  wire [16:0] nxt = step(op_q, word_q, val, cf);
  wire        is_rot = (op_q == `DALSA_OP_ROL) || (op_q == `DALSA_OP_ROR) ||
                       (op_q == `DALSA_OP_RCL) || (op_q == `DALSA_OP_RCR);
  wire        is_shift = (i_op >= `DALSA_OP_SHL) && (i_op <= `DALSA_OP_RCR);

  // a new request is refused while a shift is still stepping
  assign o_busy = (state == ST_SHIFT);

  // finishing flag word for shifts and rotates
  reg [15:0] shift_flags;

  always @* begin
    shift_flags = is_rot ? flags_q : szp(word_q, nxt[15:0], flags_q); // RULE20
    shift_flags[`DALSA_CF] = nxt[16];                        // RULE20
    if (single)
      shift_flags[`DALSA_OF] = orig_top ^ topbit(word_q, nxt[15:0]); // RULE21
  end

  // ==========================================================
  // main process: one cycle ops answer next edge, shifts step per bit
  always @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state          <= ST_IDLE;
      op_q           <= `DALSA_OP_NOT;
      word_q         <= 1'b0;
      count          <= 8'h00;
      single         <= 1'b0;
      val            <= `DALSA_DATA_RST;
      cf             <= 1'b0;
      orig_top       <= 1'b0;
      flags_q        <= `DALSA_FLAGS_RST;
      o_done         <= 1'b0;
      o_divide_error <= 1'b0;
      o_result       <= `DALSA_DATA_RST;
      o_write_dst    <= 1'b0;
      o_acc          <= `DALSA_DATA_RST;
      o_write_acc    <= 1'b0;
      o_ext          <= `DALSA_DATA_RST;
      o_write_ext    <= 1'b0;
      o_flags        <= `DALSA_FLAGS_RST;
      o_write_flags  <= 1'b0;
    end else begin
      o_done         <= 1'b0;
      o_divide_error <= 1'b0;
      o_write_dst    <= 1'b0;
      o_write_acc    <= 1'b0;
      o_write_ext    <= 1'b0;
      o_write_flags  <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (i_start) begin
            o_flags <= i_flags;
            if (is_shift) begin
              op_q     <= i_op;
              word_q   <= i_word;
              count    <= count_eff;
              single   <= (count_eff == `DALSA_ONE_SHIFT);
              val      <= i_dst & wmask(i_word);
              cf       <= i_flags[`DALSA_CF];
              orig_top <= topbit(i_word, i_dst);
              flags_q  <= i_flags;
              // a zero count changes nothing and ends at once
              if (count_eff == 8'h00)
                o_done <= 1'b1;
              else
                state <= ST_SHIFT;
            end else begin
              o_done <= 1'b1;
              case (i_op)
                `DALSA_OP_NOT: begin
                  o_result    <= logic_res & wmask(i_word);  // RULE16
                  o_write_dst <= 1'b1;
                end
                `DALSA_OP_AND, `DALSA_OP_OR, `DALSA_OP_XOR,
                `DALSA_OP_TEST: begin
                  o_result    <= logic_res & wmask(i_word);
                  o_write_dst <= (i_op != `DALSA_OP_TEST);   // RULE18
                  o_flags     <= szp(i_word, logic_res,
                                     i_flags & ~16'h0801);   // RULE14
                  o_write_flags <= 1'b1;
                end
                `DALSA_OP_DIV, `DALSA_OP_SIGNED_DIVIDE: begin
                  // a trap writes nothing back
                  o_divide_error <= div_err;
                  o_write_acc    <= ~div_err;
                  o_write_ext    <= ~div_err & i_word;
                  if (i_word) begin
                    o_acc <= quo[15:0];                      // RULE4
                    o_ext <= rem;                            // RULE4
                  end else begin
                    o_acc <= {rem[7:0], quo[7:0]};           // RULE3
                  end
                end
                `DALSA_OP_AAM: begin
                  o_acc         <= {aam_hi, aam_lo};         // RULE1
                  o_write_acc   <= 1'b1;
                  o_flags       <= szp(1'b0, {8'h00, aam_lo},
                                       i_flags);             // RULE2
                  o_write_flags <= 1'b1;
                end
                `DALSA_OP_AAD: begin
                  o_acc         <= {8'h00, aad_lo};          // RULE28
                  o_write_acc   <= 1'b1;
                  o_flags       <= szp(1'b0, {8'h00, aad_lo},
                                       i_flags);             // RULE11
                  o_write_flags <= 1'b1;
                end
                `DALSA_OP_CBW: begin
                  o_acc       <= {{8{i_acc[7]}}, i_acc[7:0]}; // RULE12
                  o_write_acc <= 1'b1;
                end
                `DALSA_OP_CWD: begin
                  o_ext       <= {16{i_acc[15]}};            // RULE13
                  o_write_ext <= 1'b1;
                end
                default: begin
                  o_done <= 1'b1;
                end
              endcase
            end
          end
        end
        ST_SHIFT: begin
          val   <= nxt[15:0];
          cf    <= nxt[16];
          count <= count - 8'h01;
          if (count == 8'h01) begin
            state         <= ST_IDLE;
            o_done        <= 1'b1;
            o_result      <= nxt[15:0];
            o_write_dst   <= 1'b1;
            o_flags       <= shift_flags;                    // RULE20
            o_write_flags <= 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // dalsa_alu

/* File: dalsa_alu_asserts.sv */
// assertions on the ports of the divide, adjust, logic and shift datapath
// assumes one clock, async active-high reset, start taken when not busy
`timescale 1ns/1ps
// ============================================================
// checker
module dalsa_alu_asserts (
  // clock and reset
  input wire        i_clock,
  input wire        i_sys_rst,
  // request and operands
  input wire        i_start,
  input wire [4:0]  i_op,
  input wire        i_word,
  input wire        i_count_sel,
  input wire [15:0] i_dst,
  input wire [15:0] i_src,
  input wire [15:0] i_acc,
  // answers
  input wire        o_busy,
  input wire        o_done,
  input wire        o_divide_error,
  input wire [15:0] o_result,
  input wire        o_write_dst,
  input wire [15:0] o_acc,
  input wire        o_write_acc,
  input wire [15:0] o_ext,
  input wire        o_write_ext,
  input wire [15:0] o_flags,
  input wire        o_write_flags
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // a start counts only when the datapath is idle
  wire take  = i_start && !o_busy;
  wire shift = (i_op >= 5'h05) && (i_op <= 5'h0B);
  wire zdiv  = i_word ? (i_src == 16'h0000) : (i_src[7:0] == 8'h00);
  sequence s_single;
    take && shift && !i_count_sel;
  endsequence
  sequence s_one_step;
    o_busy && !o_done ##1 o_done && !o_busy;
  endsequence
  AST_NONSHIFT_LAT: assert property (take && !shift |=> o_done)
    else $error("non-shift operation did not finish next cycle");
  AST_SHIFT_SINGLE: assert property (s_single |=> s_one_step)
    else $error("single shift timing wrong");
  AST_ERR_NO_WRITE: assert property (o_divide_error |->
    o_done && !o_write_acc && !o_write_ext && !o_write_flags)
    else $error("divide error with writes");
  AST_DIV_ZERO: assert property (take && (i_op == 5'h0C || i_op == 5'h0D)
    && zdiv |=> o_divide_error)
    else $error("zero divisor did not trap");
  AST_NOT_FLAGS: assert property (take && i_op == 5'h00 |=> o_write_dst
    && !o_write_flags && o_result == (~$past(i_dst) &
    ($past(i_word) ? 16'hFFFF : 16'h00FF)))
    else $error("complement wrong or flags written");
  AST_LOGIC_CLEAR: assert property (take && i_op >= 5'h01 && i_op <= 5'h04
    |=> o_write_flags && !o_flags[0] && !o_flags[11])
    else $error("logic op left carry or overflow set");
  AST_TEST_NO_DST: assert property (take && i_op == 5'h04 |=>
    !o_write_dst)
    else $error("test wrote its destination");
  AST_BYTE_EXT: assert property (take && i_op == 5'h10 |=> o_write_acc &&
    !o_write_flags && o_acc == {{8{$past(i_acc[7])}}, $past(i_acc[7:0])})
    else $error("byte sign extension wrong");
  AST_WORD_EXT: assert property (take && i_op == 5'h11 |=> o_write_ext &&
    !o_write_flags && o_ext == {16{$past(i_acc[15])}})
    else $error("word sign extension wrong");
  AST_ADJ_SPLIT: assert property (take && i_op == 5'h0E |=> o_acc ==
    {$past(i_acc[7:0]) / 8'h0A, $past(i_acc[7:0]) % 8'h0A})
    else $error("multiply adjust digits wrong");
endmodule // dalsa_alu_asserts

bind dalsa_alu dalsa_alu_asserts u_chk (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_start(i_start), .i_op(i_op), .i_word(i_word),
  .i_count_sel(i_count_sel), .i_dst(i_dst), .i_src(i_src), .i_acc(i_acc),
  .o_busy(o_busy), .o_done(o_done), .o_divide_error(o_divide_error),
  .o_result(o_result), .o_write_dst(o_write_dst), .o_acc(o_acc),
  .o_write_acc(o_write_acc), .o_ext(o_ext), .o_write_ext(o_write_ext),
  .o_flags(o_flags), .o_write_flags(o_write_flags));

/* File: dalsa_alu_tb.sv */
// self-checking bench for the divide, adjust, logic and shift datapath
// assumes the design header is on the include path
`timescale 1ns/1ps
// ============================================================
// bench
module dalsa_alu_tb;
  typedef struct packed {
    logic [4:0]  wr;   // error, dst, acc, ext, flags
    logic [15:0] res;
    logic [15:0] acc;
    logic [15:0] ext;
    logic [15:0] flg;
  } dalsa_exp_t;
  reg i_clock = 1'b0;
  reg i_sys_rst = 1'b1;
  reg i_start = 1'b0;
  reg i_word = 1'b0;
  reg i_count_sel = 1'b0;
  reg [4:0] i_op = 5'h00;
  reg [7:0] i_count_low = 8'h00;
  reg [15:0] i_dst = 16'h0000, i_src = 16'h0000, i_acc = 16'h0000;
  reg [15:0] i_ext = 16'h0000, i_flags = 16'h0000;
  wire o_busy, o_done, o_divide_error, o_write_dst, o_write_acc;
  wire o_write_ext, o_write_flags;
  wire [15:0] o_result, o_acc, o_ext, o_flags;
  int err_count = 0;
  int n_checks = 0;
  // 50 MHz
  always #10 i_clock = ~i_clock;
  dalsa_alu dut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_start(i_start), .i_op(i_op), .i_word(i_word),
    .i_count_sel(i_count_sel), .i_dst(i_dst), .i_src(i_src),
    .i_acc(i_acc), .i_ext(i_ext), .i_count_low(i_count_low),
    .i_flags(i_flags), .o_busy(o_busy), .o_done(o_done),
    .o_divide_error(o_divide_error), .o_result(o_result),
    .o_write_dst(o_write_dst), .o_acc(o_acc), .o_write_acc(o_write_acc),
    .o_ext(o_ext), .o_write_ext(o_write_ext), .o_flags(o_flags),
    .o_write_flags(o_write_flags));
  // ============================================================
  // expectation
  function automatic logic [15:0] szp(input [15:0] f, r, input w);
    logic [15:0] v;
    v = r & (w ? 16'hFFFF : 16'h00FF);
    f[7] = w ? v[15] : v[7];
    f[6] = (v == 16'h0000);
    f[2] = ~^v;
    return f;
  endfunction
  // undefined flags are expected unchanged, as the design chose
  function automatic dalsa_exp_t model();
    dalsa_exp_t x;
    logic [15:0] m, r;
    logic c, b, f, lf;
    int n, tb;
    longint dv, ds, q, rm, lim;
    m = i_word ? 16'hFFFF : 16'h00FF;
    tb = i_word ? 15 : 7;
    x = '0;
    x.flg = i_flags;
    r = i_dst & m;
    c = i_flags[0];
    n = i_count_sel ? int'(i_count_low) : 1;
    lf = (i_op == 5'h05 || i_op == 5'h08 || i_op == 5'h0A);
    case (i_op)
      5'h00: begin
        x.res = ~i_dst & m;
        x.wr = 5'b01000;
      end
      5'h01, 5'h02, 5'h03, 5'h04: begin
        x.res = m & (i_op == 5'h02 ? (i_dst | i_src) :
          (i_op == 5'h03 ? (i_dst ^ i_src) : (i_dst & i_src)));
        x.wr = (i_op == 5'h04) ? 5'b00001 : 5'b01001;
        x.flg[0] = 1'b0;
        x.flg[11] = 1'b0;
        x.flg = szp(x.flg, x.res, i_word);
      end
      5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B: begin
        for (int i = 0; i < n; i++) begin
          b = lf ? r[tb] : r[0];
          f = (i_op == 5'h07) ? r[tb] :
            ((i_op == 5'h08 || i_op == 5'h09) ? b : (i_op >= 5'h0A && c));
          r = lf ? (((r << 1) | {15'h0000, f}) & m) :
            ((r >> 1) | (f ? (m ^ (m >> 1)) : 16'h0000));
          c = b;
        end
        x.res = r;
        x.wr = (n == 0) ? 5'b00000 : 5'b01001;
        x.flg[0] = c;
        if (n == 1) x.flg[11] = r[tb] ^ i_dst[tb];
        if (i_op < 5'h08) x.flg = szp(x.flg, r, i_word);
      end
      5'h0C, 5'h0D: begin
        dv = i_word ? {i_ext, i_acc} : i_acc;
        ds = i_word ? i_src : i_src[7:0];
        lim = i_word ? 65535 : 255;
        if (i_op == 5'h0D) begin
          dv = i_word ? $signed({i_ext, i_acc}) : $signed(i_acc);
          ds = i_word ? $signed(i_src) : $signed(i_src[7:0]);
          lim = i_word ? 32767 : 127;
        end
        q = (ds == 0) ? lim + 1 : dv / ds;
        rm = (ds == 0) ? 0 : dv % ds;
        x.wr = (q > lim || q < -lim) ? 5'b10000 :
          (i_word ? 5'b00110 : 5'b00100);
        x.acc = i_word ? q[15:0] : {rm[7:0], q[7:0]};
        x.ext = rm[15:0];
      end
      5'h0E, 5'h0F: begin
        x.acc = (i_op == 5'h0E) ? {i_acc[7:0] / 8'h0A, i_acc[7:0] % 8'h0A} :
          {8'h00, 8'(i_acc[15:8] * 8'h0A + i_acc[7:0])};
        x.flg = szp(x.flg, x.acc, 1'b0);
        x.wr = 5'b00101;
      end
      5'h10: begin
        x.acc = {{8{i_acc[7]}}, i_acc[7:0]};
        x.wr = 5'b00100;
      end
      5'h11: begin
        x.ext = {16{i_acc[15]}};
        x.wr = 5'b00010;
      end
      default: x.wr = 5'b00000;
    endcase
    return x;
  endfunction
  // ============================================================
  // checking and driving
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // drives one request at a falling edge and waits for its completion
  task automatic run(input [4:0] op, input w, cs, input [15:0] d, s, a, e,
                     input [7:0] cl, input [15:0] fl);
    dalsa_exp_t x;
    int k;
    {i_op, i_word, i_count_sel, i_dst, i_src} = {op, w, cs, d, s};
    {i_acc, i_ext, i_count_low, i_flags} = {a, e, cl, fl};
    x = model();
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    for (k = 0; k < 300 && o_done !== 1'b1; k++) @(negedge i_clock);
    if (k == 300) begin
      err_count++;
      report_and_stop();
    end
    chk("writes", {11'h000, o_divide_error, o_write_dst, o_write_acc,
        o_write_ext, o_write_flags}, {11'h000, x.wr});
    if (x.wr[3]) chk("result", o_result, x.res);
    if (x.wr[2]) chk("acc", o_acc, x.acc);
    if (x.wr[1]) chk("ext", o_ext, x.ext);
    if (x.wr[0]) chk("flags", o_flags, x.flg);
    @(negedge i_clock);
  endtask
  // ============================================================
  // main sequence: corners first, then random traffic
  initial begin
    repeat (6) @(negedge i_clock);
    i_sys_rst = 1'b0;
    void'($urandom(86361));
    run(5'h0C, 0, 0, 0, 16'h0000, 16'h1234, 0, 0, 0);
    run(5'h0C, 0, 0, 0, 16'h0012, 16'h11FF, 0, 0, 0);
    run(5'h0C, 0, 0, 0, 16'h0012, 16'h1200, 0, 0, 0);
    run(5'h0D, 0, 0, 0, 16'h00FF, 16'h0080, 0, 0, 0);
    run(5'h0D, 0, 0, 0, 16'h00FF, 16'hFF81, 0, 0, 0);
    run(5'h0D, 1, 0, 0, 16'hFFFF, 16'h8001, 16'hFFFF, 0, 0);
    run(5'h0D, 1, 0, 0, 16'h0002, 16'hFFFB, 16'hFFFF, 0, 0);
    run(5'h05, 1, 1, 16'h8001, 0, 0, 0, 8'hFF, 0);
    run(5'h07, 0, 1, 16'h00FB, 0, 0, 0, 8'h01, 0);
    run(5'h06, 0, 1, 16'h00F0, 0, 0, 0, 8'h00, 16'h0FFF);
    run(5'h0E, 0, 0, 0, 0, 16'h0051, 0, 0, 0);
    run(5'h0F, 0, 0, 0, 0, 16'h0909, 0, 0, 0);
    // counts kept short mostly, so the run stays well inside its budget
    repeat (400)
      run(5'($urandom_range(18, 0)), 1'($urandom), 1'($urandom),
          16'($urandom), 16'($urandom), 16'($urandom), 16'($urandom),
          ($urandom_range(7, 0) == 0) ? 8'hFF : 8'($urandom_range(15, 0)),
          16'($urandom));
    report_and_stop();
  end
endmodule // dalsa_alu_tb
